/* hdl/dof_pkg.sv */
/*
  Constants shared by both ends of the sample output link: timing counts,
  own register offsets and field positions, output mode and drive codes.
  Assumes a single system clock at SYS_PERIOD_NS for both ends.
*/
package dof_pkg;

  localparam int unsigned DATA_W          = 16;
  localparam int unsigned PAIR_W          = DATA_W / 2;
  localparam int unsigned SYS_PERIOD_NS   = 25;

  // One output clock period is eight system cycles, one per 45 degree step.
  localparam logic [2:0]  LAST_PHASE      = 3'h7;

  localparam int unsigned NAP_TIME_NS     = 2000;
  localparam logic [7:0]  NAP_CYC         = 8'(NAP_TIME_NS / SYS_PERIOD_NS);
  localparam int unsigned DCS_MIN_PER_NS  = 500;
  localparam logic [7:0]  DCS_MIN_CYC     = 8'(DCS_MIN_PER_NS / SYS_PERIOD_NS);
  localparam logic [6:0]  DCS_LOCK_EDGES  = 7'h64;
  localparam logic [7:0]  PER_MAX         = 8'hff;

  localparam logic [3:0]  OFS_CLK_CTL     = 4'h0;
  localparam logic [3:0]  OFS_OUT_MODE    = 4'h4;
  localparam logic [3:0]  OFS_DATA_FMT    = 4'h8;
  localparam logic [3:0]  OFS_STATUS      = 4'hc;

  localparam int unsigned CC_DCS_BIT      = 0;
  localparam int unsigned CC_PHASE_LSB    = 1;
  localparam int unsigned CC_INV_BIT      = 3;
  localparam int unsigned OM_MODE_LSB     = 0;
  localparam int unsigned OM_CUR_LSB      = 2;
  localparam int unsigned OM_TERM_BIT     = 5;
  localparam int unsigned DF_TWOS_BIT     = 0;

  localparam logic [7:0]  CLK_CTL_RST     = 8'h00;
  localparam logic [7:0]  OUT_MODE_RST    = 8'h10;
  localparam logic        DATA_FMT_RST    = 1'b0;

  localparam logic [1:0]  MODE_FULL       = 2'h0;
  localparam logic [1:0]  MODE_DDR_CMOS   = 2'h1;
  localparam logic [1:0]  MODE_DDR_LVDS   = 2'h2;

  // Drive codes 0..6: 1.75, 2.1, 2.5, 3, 3.5, 4, 4.5 mA; code 7 is illegal.
  localparam logic [2:0]  CUR_DEFAULT     = 3'h4;
  localparam logic [2:0]  CUR_ILLEGAL     = 3'h7;

  localparam logic [DATA_W-1:0] CODE_MAX  = 16'hffff;
  localparam logic [DATA_W-1:0] CODE_MIN  = 16'h0000;

endpackage

/* hdl/dof_link_if.sv */
/*
  Pin bundle between the converter output formatter and the receiving logic.
  Assumes both ends are instantiated by a surrounding top or bench.
*/
`timescale 1ns/1ps
interface dof_link_if;
  logic                      fwd_sample_clock_p;
  logic                      fwd_sample_clock_n;
  logic [dof_pkg::DATA_W-1:0] chan_one_data;
  logic [dof_pkg::DATA_W-1:0] chan_two_data;
  logic [dof_pkg::PAIR_W-1:0] chan_one_ddr_pair_out;
  logic [dof_pkg::PAIR_W-1:0] chan_two_ddr_pair_out;
  logic                      chan_one_overrange_flag;
  logic                      chan_two_overrange_flag;
  logic                      shared_overrange_flag;
  logic                      drv_lvds;
  logic [2:0]                drv_current_code;
  logic                      drv_term_on;
  logic                      drv_double;

  modport dev (
    output fwd_sample_clock_p,
    output fwd_sample_clock_n,
    output chan_one_data,
    output chan_two_data,
    output chan_one_ddr_pair_out,
    output chan_two_ddr_pair_out,
    output chan_one_overrange_flag,
    output chan_two_overrange_flag,
    output shared_overrange_flag,
    output drv_lvds,
    output drv_current_code,
    output drv_term_on,
    output drv_double
  );

  modport rx (
    input fwd_sample_clock_p,
    input fwd_sample_clock_n,
    input chan_one_data,
    input chan_two_data,
    input chan_one_ddr_pair_out,
    input chan_two_ddr_pair_out,
    input chan_one_overrange_flag,
    input chan_two_overrange_flag,
    input shared_overrange_flag,
    input drv_lvds,
    input drv_current_code,
    input drv_term_on,
    input drv_double
  );
endinterface

/* hdl/dof_device.sv */
/*
  Output formatter of a two-channel sampling converter: takes sample words,
  codes them, and drives them in full-rate, DDR CMOS or DDR LVDS form with a
  forwarded clock made from the system clock by an eight-phase divider.
  Assumes samples arrive on sys_clk at most once per output clock period,
  configuration over Avalon-MM, and strap and encode pins from outside.
*/
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps

module dof_device (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic [3:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        strap_mode_pin,
  input  wire logic                        strap_dcs_pin,
  input  wire logic                        strap_lvds_pin,
  input  wire logic                        sample_clock_in_p,
  input  wire logic                        sample_clock_in_n,
  input  wire logic                        smp_valid,
  input  wire logic [dof_pkg::DATA_W-1:0]  smp_ch1,
  input  wire logic [dof_pkg::DATA_W-1:0]  smp_ch2,
  input  wire logic                        smp_ch1_over,
  input  wire logic                        smp_ch1_under,
  input  wire logic                        smp_ch2_over,
  input  wire logic                        smp_ch2_under,
  output logic                             napped,
  output logic                             dcs_locked,
  dof_link_if.dev                          link
);
  import dof_pkg::*;

  logic [7:0]        clk_ctl;
  logic [7:0]        out_mode;
  logic              fmt_twos;
  logic [4:0]        pin_s1;
  logic [4:0]        pin_s2;
  logic              enc_q;
  logic [7:0]        per_cnt;
  logic [7:0]        high_q;
  logic [7:0]        period_q;
  logic [6:0]        lock_cnt;
  logic [7:0]        nap_cnt;
  logic              low_rate_warn;
  logic              duty_warn;
  logic [2:0]        ph;
  logic [1:0]        mode;
  logic [DATA_W-1:0] pend1;
  logic [DATA_W-1:0] pend2;
  logic              pend_f1;
  logic              pend_f2;
  logic [DATA_W-1:0] word1;
  logic [DATA_W-1:0] word2;
  logic              flag1;
  logic              flag2;

  function automatic logic [DATA_W-1:0] code_word(input logic [DATA_W-1:0] v,
                                                  input logic over,
                                                  input logic under,
                                                  input logic twos);
    logic [DATA_W-1:0] w;
    w = over ? CODE_MAX : (under ? CODE_MIN : v);
    return {w[DATA_W-1] ^ twos, w[DATA_W-2:0]};
  endfunction

  // Avalon slave: one wait cycle, then the request completes.
  wire        req     = avs_read | avs_write;
  wire        wr_take = avs_write & ~avs_waitrequest;
  wire [31:0] status  = {25'h0, pin_s2[4], mode, duty_warn, low_rate_warn,
                         dcs_locked, napped};
  wire [31:0] rd_mux  = (avs_address == OFS_CLK_CTL)  ? {24'h0, clk_ctl} :
                        (avs_address == OFS_OUT_MODE) ? {24'h0, out_mode} :
                        (avs_address == OFS_DATA_FMT) ? {31'h0, fmt_twos} :
                        (avs_address == OFS_STATUS)   ? status : 32'h0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_ctl  <= CLK_CTL_RST;
      out_mode <= OUT_MODE_RST;
      fmt_twos <= DATA_FMT_RST;
    end else if (wr_take) begin
      if (avs_address == OFS_CLK_CTL) begin
        clk_ctl <= avs_writedata[7:0];
      end
      if (avs_address == OFS_OUT_MODE) begin
        out_mode <= avs_writedata[7:0];
      end
      if (avs_address == OFS_DATA_FMT) begin
        fmt_twos <= avs_writedata[DF_TWOS_BIT];
      end
    end
  end

  // Strap and encode pins cross into sys_clk through two flip-flops.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 5'h0;
      pin_s2 <= 5'h0;
    end else begin
      pin_s1 <= {strap_mode_pin, strap_dcs_pin, strap_lvds_pin,
                 sample_clock_in_p, sample_clock_in_n};
      pin_s2 <= pin_s1;
    end
  end

  wire       strap   = pin_s2[4];
  wire       enc     = pin_s2[1] & ~pin_s2[0];
  wire       enc_r   = enc & ~enc_q;
  wire       enc_f   = ~enc & enc_q;
  wire       dcs_en  = strap ? pin_s2[3] : clk_ctl[CC_DCS_BIT];
  assign mode        = strap ? (pin_s2[2] ? MODE_DDR_LVDS : MODE_FULL)
                             : out_mode[OM_MODE_LSB +: 2];
  // three modes, spare code as full
  wire       ddr     = (mode == MODE_DDR_CMOS) | (mode == MODE_DDR_LVDS);
  wire       lvds    = (mode == MODE_DDR_LVDS);
  wire [1:0] shift   = (dcs_en & ~strap) ? clk_ctl[CC_PHASE_LSB +: 2] : 2'h0;
  wire       inv     = ~strap & clk_ctl[CC_INV_BIT];
  wire [2:0] cur_reg = out_mode[OM_CUR_LSB +: 3];
  wire [2:0] cur     = (strap | (cur_reg == CUR_ILLEGAL)) ? CUR_DEFAULT : cur_reg;
  wire       term    = ~strap & out_mode[OM_TERM_BIT];
  wire       twos    = ~strap & fmt_twos;
  wire [7:0] pdiff   = (per_cnt > period_q) ? per_cnt - period_q : period_q - per_cnt;
  // Sixteen bits so twenty times a full high count cannot wrap.
  wire [15:0] h16    = {8'h0, high_q};
  wire [15:0] p16    = {8'h0, per_cnt};
  wire       duty_bad = dcs_en ? ((h16 * 16'd10 < p16) | (h16 * 16'd10 > p16 * 16'd9))
                               : ((h16 * 16'd20 < p16 * 16'd9) |
                                  (h16 * 16'd20 > p16 * 16'd11));

  // Encode monitor: period, high time, relock and nap detection.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_q         <= 1'b0;
      per_cnt       <= 8'h0;
      high_q        <= 8'h0;
      period_q      <= 8'h0;
      lock_cnt      <= 7'h0;
      low_rate_warn <= 1'b0;
      duty_warn     <= 1'b0;
    end else begin
      enc_q <= enc;
      if (enc_f) begin
        high_q <= per_cnt;
      end
      if (enc_r) begin
        per_cnt       <= 8'h1;
        period_q      <= per_cnt;
        duty_warn     <= duty_bad;
        low_rate_warn <= dcs_en & (per_cnt > DCS_MIN_CYC);
      end else if (per_cnt != PER_MAX) begin
        per_cnt <= per_cnt + 8'h1;
      end
      if (!dcs_en || (enc_r && pdiff > 8'h1)) begin
        lock_cnt <= 7'h0;
      end else if (enc_r && lock_cnt != DCS_LOCK_EDGES) begin
        lock_cnt <= lock_cnt + 7'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nap_cnt    <= 8'h0;
      napped     <= 1'b0;
      dcs_locked <= 1'b0;
    end else begin
      if (enc_r) begin
        nap_cnt <= 8'h0;
      end else if (nap_cnt < NAP_CYC) begin
        nap_cnt <= nap_cnt + 8'h1;
      end
      napped     <= (nap_cnt >= NAP_CYC);
      dcs_locked <= dcs_en & (lock_cnt == DCS_LOCK_EDGES);
    end
  end

  // Sample path. A second sample within one period overwrites the first.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph      <= 3'h0;
      pend1   <= CODE_MIN;
      pend2   <= CODE_MIN;
      pend_f1 <= 1'b0;
      pend_f2 <= 1'b0;
      word1   <= CODE_MIN;
      word2   <= CODE_MIN;
      flag1   <= 1'b0;
      flag2   <= 1'b0;
    end else begin
      ph <= ph + 3'h1;
      if (smp_valid) begin
        pend1   <= code_word(smp_ch1, smp_ch1_over, smp_ch1_under, twos);
        pend2   <= code_word(smp_ch2, smp_ch2_over, smp_ch2_under, twos);
        pend_f1 <= smp_ch1_over | smp_ch1_under;
        pend_f2 <= smp_ch2_over | smp_ch2_under;
      end
      if (ph == LAST_PHASE && !napped) begin
        word1 <= pend1;
        word2 <= pend2;
        flag1 <= pend_f1;
        flag2 <= pend_f2;
      end
    end
  end

  logic [PAIR_W-1:0] even1;
  logic [PAIR_W-1:0] odd1;
  logic [PAIR_W-1:0] even2;
  logic [PAIR_W-1:0] odd2;
  for (genvar i = 0; i < PAIR_W; i++) begin : g_split
    assign even1[i] = word1[2*i];
    assign odd1[i]  = word1[2*i+1];
    assign even2[i] = word2[2*i];
    assign odd2[i]  = word2[2*i+1];
  end

  wire [2:0] ph_sh = ph - {1'b0, shift};
  wire       clk_lv = ph_sh[2] ^ inv;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.fwd_sample_clock_p      <= 1'b0;
      link.fwd_sample_clock_n      <= 1'b1;
      link.chan_one_data           <= CODE_MIN;
      link.chan_two_data           <= CODE_MIN;
      link.chan_one_ddr_pair_out   <= '0;
      link.chan_two_ddr_pair_out   <= '0;
      link.chan_one_overrange_flag <= 1'b0;
      link.chan_two_overrange_flag <= 1'b0;
      link.shared_overrange_flag   <= 1'b0;
      link.drv_lvds                <= 1'b0;
      link.drv_current_code        <= CUR_DEFAULT;
      link.drv_term_on             <= 1'b0;
      link.drv_double              <= 1'b0;
    end else begin
      link.fwd_sample_clock_p      <= clk_lv;
      link.fwd_sample_clock_n      <= ~clk_lv;
      link.chan_one_data           <= ddr ? CODE_MIN : word1;
      link.chan_two_data           <= ddr ? CODE_MIN : word2;
      link.chan_one_overrange_flag <= ~ddr & flag1;
      link.chan_two_overrange_flag <= ~ddr & flag2;
      link.chan_one_ddr_pair_out   <= ddr ? (ph[2] ? odd1 : even1) : '0;
      link.chan_two_ddr_pair_out   <= ddr ? (ph[2] ? odd2 : even2) : '0;
      link.shared_overrange_flag   <= ddr & (ph[2] ? flag1 : flag2);
      link.drv_lvds                <= lvds;
      link.drv_current_code        <= cur;
      link.drv_term_on             <= lvds & term;
      link.drv_double              <= lvds & term;
    end
  end

endmodule

/* hdl/dof_receiver.sv */
/*
  Receiving end of the sample output link: resamples the forwarded clock and
  data on sys_clk, finds clock edges and rebuilds both channel words.
  Assumes zero phase shift, no clock inversion, and rx_ddr set by its user
  to match the mode programmed in the converter.
*/
`timescale 1ns/1ps
module dof_receiver (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic                        rx_ddr,
  dof_link_if.rx                           link,
  output logic                             rx_valid,
  output logic      [dof_pkg::DATA_W-1:0]  rx_ch1_word,
  output logic      [dof_pkg::DATA_W-1:0]  rx_ch2_word,
  output logic                             rx_ch1_flag,
  output logic                             rx_ch2_flag
);
  import dof_pkg::*;

  localparam int unsigned LW = 1 + 2 * DATA_W + 2 * PAIR_W + 3;

  logic [LW-1:0]     s1;
  logic [LW-1:0]     s2;
  logic [LW-1:0]     s3;
  logic [PAIR_W-1:0] even1;
  logic [PAIR_W-1:0] even2;
  logic              hold_f2;
  logic [DATA_W-1:0] cat1;
  logic [DATA_W-1:0] cat2;

  // The p clock leg and every data, pair and flag pin are resampled so clock and data keep the same latency.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= {link.fwd_sample_clock_p, link.chan_one_data, link.chan_two_data,
             link.chan_one_ddr_pair_out, link.chan_two_ddr_pair_out,
             link.chan_one_overrange_flag, link.chan_two_overrange_flag,
             link.shared_overrange_flag};
      s2 <= s1;
      s3 <= s2;
    end
  end

  wire               clk_rise = s2[LW-1] & ~s3[LW-1];
  wire               clk_fall = ~s2[LW-1] & s3[LW-1];
  wire [DATA_W-1:0]  d1       = s3[LW-2 -: DATA_W];
  wire [DATA_W-1:0]  d2       = s3[LW-2-DATA_W -: DATA_W];
  wire [PAIR_W-1:0]  p1       = s3[PAIR_W+3 +: PAIR_W];
  wire [PAIR_W-1:0]  p2       = s3[3 +: PAIR_W];
  wire               of1      = s3[2];
  wire               of2      = s3[1];
  wire               ofs      = s3[0];

  for (genvar i = 0; i < PAIR_W; i++) begin : g_join
    assign cat1[2*i]   = even1[i];
    assign cat1[2*i+1] = p1[i];
    assign cat2[2*i]   = even2[i];
    assign cat2[2*i+1] = p2[i];
  end

  // The s3 stage holds the value seen just before each detected edge.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      even1       <= '0;
      even2       <= '0;
      hold_f2     <= 1'b0;
      rx_valid    <= 1'b0;
      rx_ch1_word <= '0;
      rx_ch2_word <= '0;
      rx_ch1_flag <= 1'b0;
      rx_ch2_flag <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_ddr && clk_rise) begin
        rx_ch1_word <= d1;
        rx_ch2_word <= d2;
        rx_ch1_flag <= of1;
        rx_ch2_flag <= of2;
        rx_valid    <= 1'b1;
      end
      if (rx_ddr && clk_rise) begin
        even1   <= p1;
        even2   <= p2;
        hold_f2 <= ofs;
      end
      if (rx_ddr && clk_fall) begin
        rx_ch1_word <= cat1;
        rx_ch2_word <= cat2;
        rx_ch1_flag <= ofs;
        rx_ch2_flag <= hold_f2;
        rx_valid    <= 1'b1;
      end
    end
  end

endmodule

/* test/dof_link_sva.sv */
/*
  Checker on the pins between the output formatter and its receiver.
  Assumes zero phase shift and no clock inversion while the bench runs.
*/
`timescale 1ns/1ps
module dof_link_sva (
  input logic                        sys_clk,
  input logic                        rst_n,
  input logic                        fwd_sample_clock_p,
  input logic                        fwd_sample_clock_n,
  input logic [dof_pkg::DATA_W-1:0]  chan_one_data,
  input logic [dof_pkg::DATA_W-1:0]  chan_two_data,
  input logic [dof_pkg::PAIR_W-1:0]  chan_one_ddr_pair_out,
  input logic [dof_pkg::PAIR_W-1:0]  chan_two_ddr_pair_out,
  input logic                        chan_one_overrange_flag,
  input logic                        chan_two_overrange_flag,
  input logic                        shared_overrange_flag,
  input logic                        drv_lvds,
  input logic [2:0]                  drv_current_code,
  input logic                        drv_term_on,
  input logic                        drv_double
);
  import dof_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_clk_legs; fwd_sample_clock_n == !fwd_sample_clock_p; endproperty
  a_clk_legs: assert property (p_clk_legs) else $error("clock legs equal");
  property p_clk_half;
    $rose(fwd_sample_clock_p) |-> fwd_sample_clock_p [*4] ##1 !fwd_sample_clock_p;
  endproperty
  a_clk_half: assert property (p_clk_half) else $error("clock high not 4 cycles");
  property p_full_fall;
    ($changed(chan_one_data) && chan_one_data != '0 && $past(chan_one_data) != '0)
      |-> $fell(fwd_sample_clock_p);
  endproperty
  a_full_fall: assert property (p_full_fall) else $error("word moved off fall");
  property p_ddr_edges;
    ($changed(chan_two_ddr_pair_out) && chan_two_ddr_pair_out != '0
      && $past(chan_two_ddr_pair_out) != '0) |-> $changed(fwd_sample_clock_p);
  endproperty
  a_ddr_edges: assert property (p_ddr_edges) else $error("pair moved off edge");
  property p_flag_align;
    ($changed(chan_one_overrange_flag) && chan_one_data != '0
      && $past(chan_one_data) != '0) |-> $fell(fwd_sample_clock_p);
  endproperty
  a_flag_align: assert property (p_flag_align) else $error("flag off word");
  property p_ddr_shared;
    drv_lvds |-> !chan_one_overrange_flag && !chan_two_overrange_flag
      && chan_one_data == '0 && chan_two_data == '0;
  endproperty
  a_ddr_shared: assert property (p_ddr_shared) else $error("full pins in ddr");
  property p_term_double;
    drv_double == drv_term_on && (!drv_term_on || drv_lvds);
  endproperty
  a_term_double: assert property (p_term_double) else $error("term drive bad");
  property p_cur_legal; drv_current_code != CUR_ILLEGAL; endproperty
  a_cur_legal: assert property (p_cur_legal) else $error("illegal drive code");
  c_shared: cover property ($rose(shared_overrange_flag));
  c_flag_two: cover property ($rose(chan_two_overrange_flag));
  c_term: cover property ($rose(drv_term_on));
endmodule

/* test/tb_top.sv */
/*
  Bench: device and receiver joined by the link; model words compared at rx.
  Assumes the receiver is set to the mode programmed into the device.
*/
`timescale 1ns/1ps
module tb_top;
  import dof_pkg::*;
  logic sys_clk = 0, rst_n = 0, enc = 0, enc_run = 1, rx_ddr = 0, rx_valid;
  logic avs_read = 0, avs_write = 0, avs_waitrequest, napped, dcs_locked;
  logic [3:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic strap_mode = 0, strap_dcs = 0, strap_lvds = 0, smp_valid = 0;
  logic [15:0] ch1 = '0, ch2 = '0, rx_w1, rx_w2;
  logic [3:0]  fl = '0;
  logic rx_f1, rx_f2;
  int n_fail = 0, n_tests = 0;
  dof_link_if u_dof_link_if ();
  dof_device u_dof_device (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .strap_mode_pin(strap_mode), .strap_dcs_pin(strap_dcs), .strap_lvds_pin(strap_lvds),
    .sample_clock_in_p(enc), .sample_clock_in_n(1'b0), .smp_valid(smp_valid),
    .smp_ch1(ch1), .smp_ch2(ch2), .smp_ch1_over(fl[3]), .smp_ch1_under(fl[2]),
    .smp_ch2_over(fl[1]), .smp_ch2_under(fl[0]), .napped(napped),
    .dcs_locked(dcs_locked), .link(u_dof_link_if.dev));
  dof_receiver u_dof_receiver (.sys_clk(sys_clk), .rst_n(rst_n), .rx_ddr(rx_ddr),
    .link(u_dof_link_if.rx), .rx_valid(rx_valid), .rx_ch1_word(rx_w1),
    .rx_ch2_word(rx_w2), .rx_ch1_flag(rx_f1), .rx_ch2_flag(rx_f2));
  dof_link_sva u_dof_link_sva (.sys_clk(sys_clk), .rst_n(rst_n),
    .fwd_sample_clock_p(u_dof_link_if.fwd_sample_clock_p),
    .fwd_sample_clock_n(u_dof_link_if.fwd_sample_clock_n),
    .chan_one_data(u_dof_link_if.chan_one_data),
    .chan_two_data(u_dof_link_if.chan_two_data),
    .chan_one_ddr_pair_out(u_dof_link_if.chan_one_ddr_pair_out),
    .chan_two_ddr_pair_out(u_dof_link_if.chan_two_ddr_pair_out),
    .chan_one_overrange_flag(u_dof_link_if.chan_one_overrange_flag),
    .chan_two_overrange_flag(u_dof_link_if.chan_two_overrange_flag),
    .shared_overrange_flag(u_dof_link_if.shared_overrange_flag),
    .drv_lvds(u_dof_link_if.drv_lvds), .drv_current_code(u_dof_link_if.drv_current_code),
    .drv_term_on(u_dof_link_if.drv_term_on), .drv_double(u_dof_link_if.drv_double));
  initial forever #12.5 sys_clk = ~sys_clk;
  // The encode clock is unrelated in phase to sys_clk on purpose.
  // encode at 5 Msps, above the stabilizer floor.
  initial begin
    #7;
    forever #100 enc <= enc_run ? ~enc : 1'b0;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic avs(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) begin
      n_fail++;
      finish_test();
    end
  endtask
  function automatic logic [15:0] mdl(logic [15:0] r, logic o, logic u, logic t);
    logic [15:0] v;
    v = o ? CODE_MAX : (u ? CODE_MIN : r);
    return t ? {~v[15], v[14:0]} : v;
  endfunction
  task automatic smp(input logic [15:0] a, b, input logic [3:0] f, input logic t);
    @(posedge sys_clk);
    smp_valid <= 1'b1;
    ch1 <= a;
    ch2 <= b;
    fl <= f;
    @(posedge sys_clk);
    smp_valid <= 1'b0;
    repeat (32) @(negedge sys_clk);
    chk("ch1 word", mdl(a, f[3], f[2], t), rx_w1);
    chk("ch2 word", mdl(b, f[1], f[0], t), rx_w2);
    chk("ch1 flag", f[3] | f[2], rx_f1);
    chk("ch2 flag", f[1] | f[0], rx_f2);
  endtask
  initial begin
    logic [2:0] cur;
    void'($urandom(28167));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    avs(1, OFS_CLK_CTL, 0); chk("clk_ctl", CLK_CTL_RST, q);
    avs(1, OFS_OUT_MODE, 0); chk("out_mode", OUT_MODE_RST, q);
    avs(1, OFS_DATA_FMT, 0); chk("data_fmt", DATA_FMT_RST, q);
    avs(0, 4'h2, 32'hff); avs(1, 4'h2, 0); chk("unmapped", 0, q);
    $display("register test done");
    for (int m = 0; m < 3; m++) begin
      for (int f = 0; f < 2; f++) begin
        cur = 3'((m * 2 + f * 5) % 8);
        avs(0, OFS_OUT_MODE, {26'h0, f[0], cur, m[1:0]});
        avs(0, OFS_DATA_FMT, f);
        rx_ddr <= (m != 0);
        avs(1, OFS_STATUS, 0); chk("status mode", m, q[5:4]);
        chk("lvds", m == 2, u_dof_link_if.drv_lvds);
        chk("current", cur == CUR_ILLEGAL ? CUR_DEFAULT : cur,
            u_dof_link_if.drv_current_code);
        chk("term", m == 2 && f == 1, u_dof_link_if.drv_double);
        smp(16'h8000, 16'h8000, 4'h0, f[0]);
        smp(16'h1234, 16'h4321, 4'h9, f[0]);
        smp(16'h0001, 16'hfffe, 4'h6, f[0]);
        for (int s = 0; s < 3; s++) begin
          smp(16'($urandom), 16'($urandom), 4'($urandom), f[0]);
        end
        $display("mode %0d format %0d test done", m, f);
      end
    end
    avs(0, OFS_DATA_FMT, 0);
    strap_mode <= 1'b1;
    strap_lvds <= 1'b1;
    rx_ddr <= 1'b1;
    smp(16'h00ff, 16'hff00, 4'h8, 1'b0);
    chk("strap lvds", 1, u_dof_link_if.drv_lvds);
    @(posedge sys_clk);
    strap_mode <= 1'b0;
    $display("strap test done");
    avs(0, OFS_CLK_CTL, 32'h1);
    repeat (400) @(negedge sys_clk);
    chk("early lock", 0, dcs_locked);
    repeat (500) @(negedge sys_clk);
    chk("lock", 1, dcs_locked);
    avs(1, OFS_STATUS, 0); chk("lock status", 4'h2, q[3:0]);
    $display("stabilizer test done");
    enc_run <= 1'b0;
    repeat (100) @(negedge sys_clk);
    chk("nap", 1, napped);
    enc_run <= 1'b1;
    repeat (40) @(negedge sys_clk);
    chk("wake", 0, napped);
    $display("nap test done");
    finish_test();
  end
endmodule
